// ### wdt_divider.sv
// divider chain of the watchdog with a selectable time-out tap
`timescale 1ns/1ps
`default_nettype none
module wdt_divider
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic [1:0] sel,
  // state
  output logic [CNT_W-1:0] count,
  output logic tick
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // tick on the last count of the interval; wrap keeps it periodic
  assign tick = !clear && (count_reg == wdt_terminal(sel));
  assign count_next = (clear || tick) ? '0 : count_reg + 1'b1;
  assign count = count_reg;

  // free-running count, no enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : wdt_divider
`default_nettype wire

// ### wdt_pkg.sv
// constants, register map and field layout of the watchdog timer
package wdt_pkg;

  // ************************************************
  // bus and register geometry
  // ************************************************
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;
  localparam logic [APB_AW-1:0] OFS_WDC = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CKC = 8'h04;
  localparam logic [APB_AW-1:0] OFS_EIE = 8'h08;
  localparam logic [APB_AW-1:0] OFS_GIE = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_TA = 8'h10;
  localparam logic [APB_AW-1:0] OFS_STS = 8'h14;

  // ************************************************
  // field positions
  // ************************************************
  localparam int WDC_RESTART = 0;
  localparam int WDC_REN = 1;
  localparam int WDC_CAUSE = 2;
  localparam int WDC_TOF = 3;
  localparam int CKC_SEL_HI = 7;
  localparam int CKC_SEL_LO = 6;
  localparam int EIE_WDT = 5;
  localparam int GIE_BIT = 7;
  localparam int STS_GRACE = 0;
  localparam int STS_SYSRST = 1;
  localparam int STS_TA = 2;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // ************************************************
  // timing counts in clocks
  // ************************************************
  localparam int CNT_W = 21;
  localparam int unsigned IVL_00 = 4096;
  localparam int unsigned IVL_01 = 32768;
  localparam int unsigned IVL_10 = 262144;
  localparam int unsigned IVL_11 = 2097152;
  localparam int GRACE_CLKS = 512;
  localparam int GRACE_W = 9;
  localparam logic [GRACE_W-1:0] GRACE_LAST = GRACE_W'(GRACE_CLKS - 1);
  localparam int MC_CLKS = 4;
  localparam int SYSRST_CLKS = 2 * MC_CLKS;
  localparam int RST_W = 3;
  localparam logic [RST_W-1:0] RST_LAST = RST_W'(SYSRST_CLKS - 1);

  // ************************************************
  // timed access unlock
  // ************************************************
  localparam logic [REG_W-1:0] TA_KEY1 = 8'hAA;
  localparam logic [REG_W-1:0] TA_KEY2 = 8'h55;
  localparam int TA_W = 4;
  localparam logic [TA_W-1:0] TA_WINDOW_CLKS = 4'h8;

  typedef enum logic [1:0] {ST_COUNT, ST_GRACE, ST_SYSRST} wdt_state_t;

  // last count value of the selected interval
  function automatic logic [CNT_W-1:0] wdt_terminal(input logic [1:0] sel);
    logic [CNT_W-1:0] t;
    t = CNT_W'(IVL_00 - 1);
    unique case (sel)
      2'h0: t = CNT_W'(IVL_00 - 1);
      2'h1: t = CNT_W'(IVL_01 - 1);
      2'h2: t = CNT_W'(IVL_10 - 1);
      2'h3: t = CNT_W'(IVL_11 - 1);
    endcase
    return t;
  endfunction : wdt_terminal

endpackage : wdt_pkg

// ### wdt_sys_model.sv
// model of the system reset logic that sits beside the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_model (
  // clock
  input wire logic pclk,
  // watchdog side
  input wire logic sys_rst_out,
  output logic pfail_rst,
  // bench side
  input wire logic pfail_req,
  output logic [7:0] last_width,
  output logic [7:0] pulse_count
);
  logic [2:0] hold_reg = 3'h0;
  logic [7:0] width_reg = 8'h0;

  // ************************************************
  // power-fail pulse
  // ************************************************
  // held 4 clocks so the 2-flop synchroniser cannot miss it
  always @(posedge pclk) begin
    if (pfail_req) begin
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign pfail_rst = (hold_reg != 3'h0);

  // ************************************************
  // reset pulse width meter
  // ************************************************
  // sampled mid-cycle so the count never races the launching edge
  initial begin
    last_width = 8'h0;
    pulse_count = 8'h0;
  end
  always @(negedge pclk) begin
    if (sys_rst_out === 1'b1) begin
      width_reg <= width_reg + 8'h1;
    end else if (width_reg != 8'h0) begin
      last_width <= width_reg;
      pulse_count <= pulse_count + 8'h1;
      width_reg <= 8'h0;
    end
  end
endmodule : wdt_sys_model
`default_nettype wire

// ### wdt_top.sv
// watchdog timer with apb register access
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // system side
  input wire logic pfail_rst,
  output logic sys_rst_out,
  output logic wdt_irq
);

  // ************************************************
  // declarations
  // ************************************************
  logic pfail_meta_reg, pfail_sync_reg;
  logic acc_wr, setup_rd, addr_ok, prot_wr;
  logic hit_wdc, hit_ckc, hit_eie, hit_gie, hit_ta, hit_sts;
  logic wr_wdc, wr_ckc, wr_eie, wr_gie;
  logic ta_open, ta_key1, ta_key2;
  logic ta_armed_reg, ta_armed_next;
  logic [TA_W-1:0] ta_win_reg, ta_win_next;
  logic rst_en_reg, rst_en_next;
  logic toflag_reg, toflag_next;
  logic cause_reg, cause_next;
  logic restart_reg, restart_next;
  logic [1:0] sel_reg, sel_next;
  logic eie_reg, eie_next;
  logic gie_reg, gie_next;
  logic hard_clr, wd_rst, enter_rst, div_clear, tick;
  logic [CNT_W-1:0] div_count;
  wdt_state_t state_reg, state_next;
  logic [GRACE_W-1:0] grace_reg, grace_next;
  logic [RST_W-1:0] rcnt_reg, rcnt_next;
  logic [REG_W-1:0] wdc_rd, ckc_rd, eie_rd, gie_rd, sts_rd, rd_byte;
  logic [APB_DW-1:0] prdata_reg;

  // ************************************************
  // power-fail pin
  // ************************************************

  // two-stage synchroniser; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfail_meta_reg <= 1'b0;
      pfail_sync_reg <= 1'b0;
    end else begin
      pfail_meta_reg <= pfail_rst;
      pfail_sync_reg <= pfail_meta_reg;
    end
  end

  // power-fail clears the watchdog like power-on but keeps interval select, interrupt enables and the timed access unlock state
  assign hard_clr = pfail_sync_reg;

  // ************************************************
  // apb decode
  // ************************************************

  // writes land in the access phase, reads latch in setup
  assign acc_wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign hit_wdc = (paddr == OFS_WDC);
  assign hit_ckc = (paddr == OFS_CKC);
  assign hit_eie = (paddr == OFS_EIE);
  assign hit_gie = (paddr == OFS_GIE);
  assign hit_ta = (paddr == OFS_TA);
  assign hit_sts = (paddr == OFS_STS);
  assign addr_ok = hit_wdc | hit_ckc | hit_eie | hit_gie | hit_ta | hit_sts;
  assign wr_wdc = acc_wr && hit_wdc;
  assign wr_ckc = acc_wr && hit_ckc;
  assign wr_eie = acc_wr && hit_eie;
  assign wr_gie = acc_wr && hit_gie;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ************************************************
  // timed access unlock
  // ************************************************

  // first key arms, second key opens the window
  assign ta_key1 = acc_wr && hit_ta && (pwdata[REG_W-1:0] == TA_KEY1);
  assign ta_key2 = acc_wr && hit_ta && ta_armed_reg
                   && (pwdata[REG_W-1:0] == TA_KEY2);
  assign ta_armed_next = ta_key1 ? 1'b1
                       : (acc_wr && hit_ta) ? 1'b0
                       : ta_armed_reg;
  assign ta_open = (ta_win_reg != '0);

  // the window closes after one protected write or on timeout,
  // so a runaway loop cannot reuse a stale unlock
  assign ta_win_next = ta_key2 ? TA_WINDOW_CLKS
                     : prot_wr ? '0
                     : ta_open ? ta_win_reg - 1'b1
                     : ta_win_reg;
  assign prot_wr = wr_wdc && ta_open;

  // unlock state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ta_armed_reg <= 1'b0;
      ta_win_reg <= '0;
    end else begin
      ta_armed_reg <= ta_armed_next;
      ta_win_reg <= ta_win_next;
    end
  end

  // ************************************************
  // control and flag registers
  // ************************************************

  // reset enable is dropped only by power-fail or a protected write, not by own reset
  assign rst_en_next = hard_clr ? 1'b0
                     : prot_wr ? pwdata[WDC_REN]
                     : rst_en_reg;

  // hardware set beats a software clear in the same cycle
  assign toflag_next = (hard_clr || wd_rst) ? 1'b0
                     : tick ? 1'b1
                     : prot_wr ? pwdata[WDC_TOF]
                     : toflag_reg;

  // cause flag: plain write, set on reset entry only
  assign cause_next = hard_clr ? 1'b0
                    : enter_rst ? 1'b1
                    : wr_wdc ? pwdata[WDC_CAUSE]
                    : cause_reg;

  // restart reads back as one for a single cycle
  assign restart_next = prot_wr && pwdata[WDC_RESTART]
                        && !hard_clr;

  // interval select and interrupt enables
  assign sel_next = wr_ckc ? pwdata[CKC_SEL_HI:CKC_SEL_LO]
                  : sel_reg;
  assign eie_next = wr_eie ? pwdata[EIE_WDT] : eie_reg;
  assign gie_next = wr_gie ? pwdata[GIE_BIT] : gie_reg;

  // register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_en_reg <= 1'b0;
      toflag_reg <= 1'b0;
      cause_reg <= 1'b0;
      restart_reg <= 1'b0;
      sel_reg <= SEL_RESET;
      eie_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else begin
      rst_en_reg <= rst_en_next;
      toflag_reg <= toflag_next;
      cause_reg <= cause_next;
      restart_reg <= restart_next;
      sel_reg <= sel_next;
      eie_reg <= eie_next;
      gie_reg <= gie_next;
    end
  end

  // ************************************************
  // divider and time-out sequence
  // ************************************************

  // restart, own reset and power-fail all restart the divider
  assign div_clear = restart_reg || wd_rst || hard_clr;

  wdt_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(div_clear),
    .sel(sel_reg),
    .count(div_count),
    .tick(tick)
  );

  // count, grace window, then system reset if enabled
  always_comb begin
    state_next = state_reg;
    grace_next = grace_reg;
    rcnt_next = rcnt_reg;
    unique case (state_reg)
      ST_COUNT: begin
        if (tick) begin
          state_next = ST_GRACE;
          grace_next = '0;
        end
      end
      ST_GRACE: begin
        grace_next = grace_reg + 1'b1;
        if (restart_reg) begin
          state_next = ST_COUNT;
        end else if (grace_reg == GRACE_LAST) begin
          if (rst_en_reg) begin
            state_next = ST_SYSRST;
            rcnt_next = '0;
          end else begin
            state_next = ST_COUNT;
          end
        end
      end
      ST_SYSRST: begin
        rcnt_next = rcnt_reg + 1'b1;
        if (rcnt_reg == RST_LAST) begin
          state_next = ST_COUNT;
        end
      end
      default: state_next = ST_COUNT; // unused code falls back to counting
    endcase
    if (hard_clr) begin
      state_next = ST_COUNT;
    end
  end

  // sequence state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_COUNT;
      grace_reg <= '0;
      rcnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      grace_reg <= grace_next;
      rcnt_reg <= rcnt_next;
    end
  end

  // reset and interrupt are gated independently
  assign enter_rst = (state_reg == ST_GRACE) && (state_next == ST_SYSRST);
  assign wd_rst = (state_reg == ST_SYSRST);
  assign sys_rst_out = wd_rst;
  assign wdt_irq = toflag_reg && eie_reg && gie_reg;

  // ************************************************
  // read path
  // ************************************************

  // pack fields; unused bits read zero
  always_comb begin
    wdc_rd = '0;
    ckc_rd = '0;
    eie_rd = '0;
    gie_rd = '0;
    sts_rd = '0;
    wdc_rd[WDC_RESTART] = restart_reg;
    wdc_rd[WDC_REN] = rst_en_reg;
    wdc_rd[WDC_CAUSE] = cause_reg;
    wdc_rd[WDC_TOF] = toflag_reg;
    ckc_rd[CKC_SEL_HI:CKC_SEL_LO] = sel_reg;
    eie_rd[EIE_WDT] = eie_reg;
    gie_rd[GIE_BIT] = gie_reg;
    sts_rd[STS_GRACE] = (state_reg == ST_GRACE);
    sts_rd[STS_SYSRST] = wd_rst;
    sts_rd[STS_TA] = ta_open;
  end

  // key register reads zero so keys never leak back
  assign rd_byte = hit_wdc ? wdc_rd
                 : hit_ckc ? ckc_rd
                 : hit_eie ? eie_rd
                 : hit_gie ? gie_rd
                 : hit_sts ? sts_rd
                 : '0;

  // read data captured in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= {{(APB_DW-REG_W){1'b0}}, rd_byte};
    end
  end

  assign prdata = prdata_reg;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb_wdt @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_timeout_flag;
    tick && !wd_rst |=> toflag_reg;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("time-out did not set flag");

  property p_grace_reset;
    state_reg == ST_GRACE && grace_reg == GRACE_LAST && !restart_reg
      && rst_en_reg && !hard_clr |=> sys_rst_out;
  endproperty
  a_grace_reset: assert property (p_grace_reset)
    else $error("no reset after grace window");

  property p_rst_len;
    $rose(sys_rst_out) && !hard_clr |-> sys_rst_out[*8] ##1 !sys_rst_out;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");

  property p_cause_set;
    $rose(sys_rst_out) |-> cause_reg;
  endproperty
  a_cause_set: assert property (p_cause_set)
    else $error("cause flag not set");

  property p_reset_needs_en;
    $rose(sys_rst_out) |-> $past(rst_en_reg);
  endproperty
  a_reset_needs_en: assert property (p_reset_needs_en)
    else $error("reset without enable");

  property p_irq_gate;
    $rose(wdt_irq) |-> $past(tick) || $past(prot_wr) || $past(wr_eie)
      || $past(wr_gie);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated");

  property p_restart_clears;
    restart_reg |=> div_count == '0 && !restart_reg;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear counter");

  property p_pfail_disable;
    hard_clr |=> !rst_en_reg && !cause_reg && !toflag_reg;
  endproperty
  a_pfail_disable: assert property (p_pfail_disable)
    else $error("power-fail left watchdog armed");

  property p_locked;
    wr_wdc && !ta_open && !hard_clr |=> $stable(rst_en_reg);
  endproperty
  a_locked: assert property (p_locked)
    else $error("protected bit changed while locked");

  property p_wdrst_keeps;
    $fell(sys_rst_out) && !hard_clr |-> rst_en_reg && div_count == '0;
  endproperty
  a_wdrst_keeps: assert property (p_wdrst_keeps)
    else $error("own reset disabled the watchdog");

endmodule : wdt_top
`default_nettype wire

// ### wdt_top_tb.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wdt_top_tb
  import wdt_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, e, pready, pslverr;
  logic pfail_rst, sys_rst_out, wdt_irq, pfail_req;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, q;
  logic [7:0] last_width, pulse_count;
  int fail_count, total_checks, n;

  wdt_top u_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pfail_rst(pfail_rst), .sys_rst_out(sys_rst_out), .wdt_irq(wdt_irq));
  wdt_sys_model u_wdt_sys_model (.pclk(pclk), .sys_rst_out(sys_rst_out),
    .pfail_rst(pfail_rst), .pfail_req(pfail_req),
    .last_width(last_width), .pulse_count(pulse_count));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; only the bench timeout ends a hang on pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd_chk

  task automatic unlock();
    wr(OFS_TA, {24'h0, TA_KEY1});
    wr(OFS_TA, {24'h0, TA_KEY2});
  endtask : unlock

  // counts cycles until irq (0) or system reset (1) shows, up to lim
  task automatic wait_sig(input logic which, input int lim, output int c);
    c = 0;
    while (((which ? sys_rst_out : wdt_irq) !== 1'b1) && c < lim) begin
      @(negedge pclk);
      c++;
    end
  endtask : wait_sig

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ************************************************
  // watchdog of the bench
  // ************************************************
  // the sequence needs about 51000 cycles; 60000 leaves margin
  initial begin
    #(60000 * 20);
    fail_count++;
    report_and_stop();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pfail_req = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    // unserviced time-out ends in a system reset
    wr(OFS_EIE, 32'h20);
    wr(OFS_GIE, 32'h80);
    unlock();
    wr(OFS_WDC, 32'h3);
    wait_sig(1'b0, 5000, n);
    chk(32'(n), 32'(IVL_00 + 2));
    wait_sig(1'b1, 600, n);
    chk(32'(n >= GRACE_CLKS - 1 && n <= GRACE_CLKS), 32'h1);
    repeat (20) @(posedge pclk);
    chk(32'(last_width), 32'(SYSRST_CLKS));
    chk({31'h0, wdt_irq}, 32'h0);
    rd_chk(OFS_WDC, 32'h6);
    // restart inside the grace phase averts the reset
    wait_sig(1'b0, 5000, n);
    chk(32'(n < 5000), 32'h1);
    unlock();
    wr(OFS_WDC, 32'h3);
    wait_sig(1'b1, 700, n);
    chk(32'(n == 700), 32'h1);
    chk({31'h0, wdt_irq}, 32'h0);
    rd_chk(OFS_WDC, 32'h2);
    // reset disabled and interrupt masked: flag only
    wr(OFS_GIE, 32'h0);
    unlock();
    wr(OFS_WDC, 32'h1);
    wait_sig(1'b0, 4700, n);
    chk(32'(n == 4700), 32'h1);
    chk(32'(pulse_count), 32'h1);
    rd_chk(OFS_WDC, 32'h8);
    wr(OFS_GIE, 32'h80);
    repeat (2) @(negedge pclk);
    chk({31'h0, wdt_irq}, 32'h1);
    unlock();
    wr(OFS_WDC, 32'h0);
    rd_chk(OFS_WDC, 32'h0);
    wait_sig(1'b0, 4200, n);
    chk(32'(n < 4200), 32'h1);
    // select field, window expiry, protection, power fail
    wr(OFS_CKC, 32'hC0);
    rd_chk(OFS_CKC, 32'hC0);
    unlock();
    repeat (10) @(posedge pclk);
    wr(OFS_WDC, 32'h6);
    rd_chk(OFS_WDC, 32'hC);
    unlock();
    wr(OFS_WDC, 32'hE);
    rd_chk(OFS_WDC, 32'hE);
    @(posedge pclk);
    pfail_req <= 1'b1;
    @(posedge pclk);
    pfail_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rd_chk(OFS_WDC, 32'h0);
    rd_chk(OFS_CKC, 32'hC0);
    // code 01 interval seen on the interrupt
    wr(OFS_CKC, 32'h40);
    unlock();
    wr(OFS_WDC, 32'h1);
    wait_sig(1'b0, 33000, n);
    chk(32'(n), 32'(IVL_01 + 2));
    report_and_stop();
  end
endmodule : wdt_top_tb
`default_nettype wire
